// >>> scf_pkg.sv
package scf_pkg;
   // register map (word index; byte address = 4 x index)
   localparam logic [3:0] ADDR_CARD_MODE = 4'h0;
   localparam logic [3:0] ADDR_STATUS = 4'h1;
   localparam logic [3:0] ADDR_CONTROL = 4'h2;
   localparam logic [3:0] ADDR_TX_DATA = 4'h3;
   localparam logic [3:0] ADDR_RX_DATA = 4'h4;
   localparam logic [3:0] ADDR_IRQ_STAT = 4'h5;
   localparam logic [3:0] ADDR_IRQ_MASK = 4'h6;
   localparam logic [3:0] ADDR_MODE = 4'h7;
   // card mode register fields
   localparam int CM_CARD_MODE_SELECT = 0;
   localparam int CM_INV = 2;
   localparam int CM_DIR = 3;
   localparam logic [7:0] CM_FIXED_ONES = 8'hF2;
   localparam logic [7:0] CM_RESET = 8'hF2;
   // status register fields
   localparam int ST_TRANSMIT_DATA_EMPTY = 7;
   localparam int ST_ERS = 4;
   localparam int ST_TRANSMIT_END_FLAG = 2;
   localparam int ST_MPB = 1;
   localparam int ST_MULTIPROC_TX_BIT = 0;
   // control register fields
   localparam int CT_TE = 5;
   localparam int CT_EPS = 3;
   // mode register fields
   localparam int MD_GM = 7;
   localparam int MD_BLK = 6;
   localparam int MD_7BIT = 5;
   // interrupt bits
   localparam int IRQ_TRANSMIT_END_FLAG = 0;
   localparam int IRQ_ERS = 1;
   // timing in tenths of an etu; etu length in clock cycles
   localparam int TRANSMIT_END_FLAG_DLY_STD_X10 = 25;
   localparam int TRANSMIT_END_FLAG_DLY_BLK_X10 = 15;
   localparam int TRANSMIT_END_FLAG_DLY_GM_X10 = 10;
   localparam int ETU_CYCLES = 40;
   typedef enum logic [1:0] {
      TX_IDLE = 2'b00,
      TX_WAIT = 2'b01,
      TX_SHIFT = 2'b10
   } scf_tx_state_t;
endpackage : scf_pkg

// >>> scf_bit_format.sv
module scf_bit_format
   import scf_pkg::*;
(
   // format controls
   input wire logic i_msb_first,
   input wire logic i_invert,
   input wire logic i_seven_bit,
   // data
   input wire logic [7:0] i_data,
   output logic [7:0] o_data
);
   logic [7:0] inv;
   logic [7:0] rev;
   // inversion touches data bits only; parity is framed elsewhere
   assign inv = i_invert ? ~i_data : i_data;
   genvar g;
   generate
      for (g = 0; g < 8; g++) begin : g_rev
         assign rev[g] = inv[7 - g];
      end
   endgenerate
   // 7-bit format ignores order select
   assign o_data = (i_msb_first && !i_seven_bit) ? rev : inv;
endmodule : scf_bit_format

// >>> scf_smartcard_format_transmit_end_flag.sv
// Overview of operation
// - transmit_end_flag set means no card error and next byte may be loaded.
// - transmit_end_flag forced to 1 while transmit enable and error control both 0.
// - transmit_end_flag set after delay from start if error status 0 and data empty 1.
// - delay 2.5 etu standard, 1.5 etu block, 1.0 etu guard mode.
// - transmit_end_flag cleared when 0 written to data empty after reading it as 1.
// - received multiprocessor bit unused in card mode, reads 0.
// - card mode bits 7..4 and 1 read 1, writes ignored.
// - bit order select 0 sends lsb first, 1 sends msb first.
// - order select only for 8-bit format; 7-bit always lsb first.
// - invert select inverts transmit and receive data.
// - inversion leaves parity untouched; software flips parity select.
// - card mode select 1 enables smart card mode.
// - error status set when a low error signal is sampled.
module scf_smartcard_format_transmit_end_flag
   import scf_pkg::*;
#(
   parameter int ETU = scf_pkg::ETU_CYCLES
) (
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   // register port
   input wire logic [3:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [7:0] o_rdata,
   // card line
   input wire logic i_card_io,
   output logic o_card_io,
   output logic o_card_io_oe,
   // receive path from framing logic
   input wire logic i_rx_valid,
   input wire logic [7:0] i_rx_raw,
   // interrupt
   output logic o_irq
);
   logic [7:0] card_mode_ff;
   logic [7:0] ctrl_ff;
   logic [7:0] mode_ff;
   logic [7:0] tx_data_ff;
   logic [7:0] rx_data_ff;
   logic [7:0] shift_ff;
   logic [1:0] irq_stat_ff;
   logic [1:0] irq_mask_ff;
   logic transmit_data_empty_ff;
   logic transmit_end_flag_ff;
   logic ers_ff;
   logic multiproc_tx_bit_ff;
   logic transmit_data_empty_seen_ff;
   logic ers_seen_ff;
   logic [7:0] rdata_ff;
   logic io_s1_ff;
   logic io_s2_ff;
   logic io_ff;
   logic oe_ff;
   scf_tx_state_t state_ff;
   logic [15:0] etu_cnt_ff;
   logic [15:0] start_cnt_ff;
   logic start_run_ff;
   logic [3:0] bit_cnt_ff;
   logic [7:0] tx_fmt;
   logic [7:0] rx_fmt;
   logic card_mode_select;
   logic te;
   logic error_signal_control_bit;
   logic seven;
   logic etu_tick;
   logic transmit_end_flag_hit;
   logic transmit_data_empty_clr;
   logic ers_clr;
   logic ers_set;
   logic load;
   logic [15:0] transmit_end_flag_dly;

   assign card_mode_select = card_mode_ff[CM_CARD_MODE_SELECT];
   assign te = ctrl_ff[CT_TE];
   assign error_signal_control_bit = ctrl_ff[CT_EPS];
   assign seven = mode_ff[MD_7BIT];

   scf_bit_format u_tx_fmt (
      .i_msb_first(card_mode_ff[CM_DIR]),
      .i_invert(card_mode_ff[CM_INV]),
      .i_seven_bit(seven),
      .i_data(tx_data_ff),
      .o_data(tx_fmt)
   );

   scf_bit_format u_rx_fmt (
      .i_msb_first(card_mode_ff[CM_DIR]),
      .i_invert(card_mode_ff[CM_INV]),
      .i_seven_bit(seven),
      .i_data(i_rx_raw),
      .o_data(rx_fmt)
   );

   // delay in cycles, tenths of etu rounded up
   always_comb begin
      if (mode_ff[MD_GM]) begin
         transmit_end_flag_dly = 16'((TRANSMIT_END_FLAG_DLY_GM_X10 * ETU + 9) / 10);
      end else if (mode_ff[MD_BLK]) begin
         transmit_end_flag_dly = 16'((TRANSMIT_END_FLAG_DLY_BLK_X10 * ETU + 9) / 10);
      end else begin
         transmit_end_flag_dly = 16'((TRANSMIT_END_FLAG_DLY_STD_X10 * ETU + 9) / 10);
      end
   end

   // flag clears need a prior read of the flag as 1
   assign transmit_data_empty_clr = i_wr && (i_addr == ADDR_STATUS) && !i_wdata[ST_TRANSMIT_DATA_EMPTY] && transmit_data_empty_seen_ff;
   assign ers_clr = i_wr && (i_addr == ADDR_STATUS) && !i_wdata[ST_ERS] && ers_seen_ff;
   assign load = (state_ff == TX_IDLE) && card_mode_select && te && !transmit_data_empty_ff;
   assign etu_tick = (etu_cnt_ff == 16'(ETU - 1));
   assign transmit_end_flag_hit = start_run_ff && (start_cnt_ff == transmit_end_flag_dly - 16'h0001);
   // error signal sampled low during guard window after the byte; the first two
   // cycles are skipped because the synchroniser still shows our own last bit
   assign ers_set = card_mode_select && (state_ff == TX_WAIT) && (etu_cnt_ff > 16'h0001) && !io_s2_ff;

   // two-flop synchroniser for card line
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         io_s1_ff <= 1'b1;
         io_s2_ff <= 1'b1;
      end else begin
         io_s1_ff <= i_card_io;
         io_s2_ff <= io_s1_ff;
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         card_mode_ff <= CM_RESET;
         ctrl_ff <= 8'h00;
         mode_ff <= 8'h00;
         tx_data_ff <= 8'h00;
         irq_mask_ff <= 2'h0;
         multiproc_tx_bit_ff <= 1'b0;
      end else if (i_wr) begin
         unique case (i_addr)
            ADDR_CARD_MODE: card_mode_ff <= i_wdata | CM_FIXED_ONES;
            ADDR_CONTROL: ctrl_ff <= i_wdata;
            ADDR_MODE: mode_ff <= i_wdata;
            ADDR_TX_DATA: tx_data_ff <= i_wdata;
            ADDR_IRQ_MASK: irq_mask_ff <= i_wdata[1:0];
            // software must keep this 0 in card mode
            ADDR_STATUS: multiproc_tx_bit_ff <= i_wdata[ST_MULTIPROC_TX_BIT];
            default: begin
            end
         endcase
      end
   end

   // read-then-clear arming
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         transmit_data_empty_seen_ff <= 1'b0;
         ers_seen_ff <= 1'b0;
      end else if (i_rd && i_addr == ADDR_STATUS) begin
         transmit_data_empty_seen_ff <= transmit_data_empty_ff;
         ers_seen_ff <= ers_ff;
      end else if (i_wr && i_addr == ADDR_STATUS) begin
         transmit_data_empty_seen_ff <= 1'b0;
         ers_seen_ff <= 1'b0;
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         transmit_data_empty_ff <= 1'b1;
      end else if (!te || load) begin
         transmit_data_empty_ff <= 1'b1;
      end else if (transmit_data_empty_clr) begin
         transmit_data_empty_ff <= 1'b0;
      end
   end

   // set beats clear so a late event is not lost
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         transmit_end_flag_ff <= 1'b1;
      end else if (!te && !error_signal_control_bit) begin
         transmit_end_flag_ff <= 1'b1;
      end else if (transmit_end_flag_hit && !ers_ff && transmit_data_empty_ff) begin
         transmit_end_flag_ff <= 1'b1;
      end else if (transmit_data_empty_clr) begin
         transmit_end_flag_ff <= 1'b0;
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ers_ff <= 1'b0;
      end else if (ers_set) begin
         ers_ff <= 1'b1;
      end else if (ers_clr) begin
         ers_ff <= 1'b0;
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rx_data_ff <= 8'h00;
      end else if (i_rx_valid && card_mode_select) begin
         rx_data_ff <= rx_fmt;
      end
   end

   // etu counter restarts at transmission start
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         etu_cnt_ff <= 16'h0000;
      end else if (load || etu_tick) begin
         etu_cnt_ff <= 16'h0000;
      end else begin
         etu_cnt_ff <= etu_cnt_ff + 16'h0001;
      end
   end

   // start-to-transmit_end_flag counter; delay measured from the start bit
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         start_cnt_ff <= 16'h0000;
         start_run_ff <= 1'b0;
      end else if (load) begin
         start_cnt_ff <= 16'h0000;
         start_run_ff <= 1'b1;
      end else if (transmit_end_flag_hit) begin
         start_run_ff <= 1'b0;
      end else if (start_run_ff) begin
         start_cnt_ff <= start_cnt_ff + 16'h0001;
      end
   end

   // simple transmit shifter: start bit, data bits, then error window
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_ff <= TX_IDLE;
         shift_ff <= 8'h00;
         bit_cnt_ff <= 4'h0;
         io_ff <= 1'b1;
         oe_ff <= 1'b0;
      end else begin
         unique case (state_ff)
            TX_IDLE: begin
               oe_ff <= 1'b0;
               io_ff <= 1'b1;
               if (load) begin
                  shift_ff <= tx_fmt;
                  bit_cnt_ff <= seven ? 4'h7 : 4'h8;
                  io_ff <= 1'b0;
                  oe_ff <= 1'b1;
                  state_ff <= TX_SHIFT;
               end
            end
            TX_SHIFT: begin
               if (etu_tick) begin
                  if (bit_cnt_ff == 4'h0) begin
                     oe_ff <= 1'b0;
                     io_ff <= 1'b1;
                     state_ff <= TX_WAIT;
                  end else begin
                     io_ff <= shift_ff[0];
                     shift_ff <= {1'b0, shift_ff[7:1]};
                     bit_cnt_ff <= bit_cnt_ff - 4'h1;
                  end
               end
            end
            TX_WAIT: begin
               if (etu_tick) begin
                  state_ff <= TX_IDLE;
               end
            end
            default: state_ff <= TX_IDLE;
         endcase
      end
   end

   // sticky interrupt status, write one to clear, set wins
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         irq_stat_ff <= 2'h0;
      end else begin
         for (int k = 0; k < 2; k++) begin
            if ((k == IRQ_TRANSMIT_END_FLAG && transmit_end_flag_hit && !ers_ff && transmit_data_empty_ff) || (k == IRQ_ERS && ers_set)) begin
               irq_stat_ff[k] <= 1'b1;
            end else if (i_wr && i_addr == ADDR_IRQ_STAT && i_wdata[k]) begin
               irq_stat_ff[k] <= 1'b0;
            end
         end
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rdata_ff <= 8'h00;
      end else if (i_rd) begin
         unique case (i_addr)
            ADDR_CARD_MODE: rdata_ff <= card_mode_ff | CM_FIXED_ONES;
            // multiprocessor receive bit reads 0 in card mode
            ADDR_STATUS: rdata_ff <= {transmit_data_empty_ff, 2'b00, ers_ff, 1'b0, transmit_end_flag_ff, 1'b0, multiproc_tx_bit_ff};
            ADDR_CONTROL: rdata_ff <= ctrl_ff;
            ADDR_TX_DATA: rdata_ff <= tx_data_ff;
            ADDR_RX_DATA: rdata_ff <= rx_data_ff;
            ADDR_IRQ_STAT: rdata_ff <= {6'h00, irq_stat_ff};
            ADDR_IRQ_MASK: rdata_ff <= {6'h00, irq_mask_ff};
            ADDR_MODE: rdata_ff <= mode_ff;
            default: rdata_ff <= 8'h00;
         endcase
      end else begin
         rdata_ff <= 8'h00;
      end
   end

   assign o_rdata = rdata_ff;
   assign o_card_io = io_ff;
   assign o_card_io_oe = oe_ff;
   assign o_irq = |(irq_stat_ff & irq_mask_ff);
endmodule : scf_smartcard_format_transmit_end_flag

// >>> scf_smartcard_format_transmit_end_flag_properties.sv
module scf_transmit_end_flag_checker
   import scf_pkg::*;
#(
   parameter int ETU = ETU_CYCLES
) (
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   input wire logic [3:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [7:0] o_rdata,
   input wire logic o_card_io,
   input wire logic o_card_io_oe,
   input wire logic o_irq
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (!i_rst_n);
   logic [7:0] mode_ff, mask_ff, ctl_ff, cnt_ff;
   logic [15:0] len_ff;
   int dly;
   // shadows of software writes, since the checker sees no internal registers
   always_comb dly = mode_ff[MD_GM] ? ETU : mode_ff[MD_BLK] ? (3*ETU+1)/2 : (5*ETU+1)/2;
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         mode_ff <= 8'h00;
         mask_ff <= 8'h00;
         ctl_ff <= 8'h00;
      end else if (i_wr) begin
         if (i_addr == ADDR_MODE) mode_ff <= i_wdata;
         if (i_addr == ADDR_IRQ_MASK) mask_ff <= i_wdata;
         if (i_addr == ADDR_CONTROL) ctl_ff <= i_wdata;
      end
   end
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) cnt_ff <= 8'h00;
      else if ($rose(o_card_io_oe)) cnt_ff <= 8'h01;
      else if (cnt_ff != 8'h00 && cnt_ff != 8'hFF) cnt_ff <= cnt_ff + 8'h01;
   end
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) len_ff <= 16'h0000;
      else len_ff <= o_card_io_oe ? len_ff + 16'h0001 : 16'h0000;
   end
   a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
      else $error("read data not zero outside read answer");
   a_cm_fixed_ones: assert property ($past(i_rd) && $past(i_addr) == ADDR_CARD_MODE |->
      (o_rdata & CM_FIXED_ONES) == CM_FIXED_ONES) else $error("card mode fixed bits not one");
   a_mpb_zero: assert property ($past(i_rd) && $past(i_addr) == ADDR_STATUS |->
      !o_rdata[ST_MPB]) else $error("receive multiproc bit not zero");
   a_unmapped_zero: assert property ($past(i_rd) && $past(i_addr) > ADDR_MODE |->
      o_rdata == 8'h00) else $error("unmapped read not zero");
   a_start_low: assert property ($rose(o_card_io_oe) |-> !o_card_io)
      else $error("frame does not open low");
   a_frame_len: assert property ($fell(o_card_io_oe) && ctl_ff[CT_TE] |->
      len_ff == 9*ETU || len_ff == 8*ETU) else $error("frame length wrong");
   a_transmit_end_flag_delay: assert property ($rose(o_irq) && cnt_ff != 0 && cnt_ff < 200 &&
      mask_ff == 8'h01 |-> cnt_ff == dly) else $error("transmit end at wrong time");
   a_irq_masked: assert property ($past(i_wr) && $past(i_addr) == ADDR_IRQ_MASK &&
      $past(i_wdata) == 8'h00 |-> !o_irq) else $error("interrupt with all masked");
   c_irq: cover property ($rose(o_irq));
   c_frame: cover property ($fell(o_card_io_oe));
   c_transmit_end_flag: cover property (cnt_ff == dly);
endmodule : scf_transmit_end_flag_checker

bind scf_smartcard_format_transmit_end_flag scf_transmit_end_flag_checker #(.ETU(ETU)) u_chk (
   .i_sys_clk(i_sys_clk),
   .i_rst_n(i_rst_n),
   .i_addr(i_addr),
   .i_wdata(i_wdata),
   .i_wr(i_wr),
   .i_rd(i_rd),
   .o_rdata(o_rdata),
   .o_card_io(o_card_io),
   .o_card_io_oe(o_card_io_oe),
   .o_irq(o_irq)
);

// >>> scf_card_model.sv
module scf_card_model #(
   parameter int ETU = 4
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_io,
   input wire logic i_oe,
   input wire logic i_err_req,
   output logic o_line,
   output logic [7:0] o_byte
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt;
   int low_cnt;
   logic oe_q;
   // pulled up when nobody pulls it low
   assign o_line = ((i_oe && !i_io) || low_cnt != 0) ? 1'b0 : 1'b1;
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cnt <= 0;
         low_cnt <= 0;
         oe_q <= 1'b0;
         o_byte <= 8'h00;
      end else begin
         oe_q <= i_oe;
         cnt <= i_oe ? cnt + 1 : 0;
         if (i_oe && cnt == 0) o_byte <= 8'h00;
         else if (i_oe && cnt >= ETU && cnt % ETU == ETU / 2) o_byte <= {i_io, o_byte[7:1]};
         // error signal only on request, held for one etu starting right after the last bit
         if (oe_q && !i_oe && i_err_req) low_cnt <= ETU;
         else if (low_cnt != 0) low_cnt <= low_cnt - 1;
      end
   end
endmodule : scf_card_model

// >>> scf_smartcard_format_transmit_end_flag_bench.sv
module scf_smartcard_format_transmit_end_flag_bench;
   import scf_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int ETU = 4;
   logic i_sys_clk = 1'b0;
   logic i_rst_n = 1'b0;
   logic [3:0] i_addr = 4'h0;
   logic [7:0] i_wdata = 8'h00;
   logic i_wr = 1'b0;
   logic i_rd = 1'b0;
   logic i_rx_valid = 1'b0;
   logic [7:0] i_rx_raw = 8'h00;
   logic err_req = 1'b0;
   logic [7:0] o_rdata, rx_byte, d;
   logic o_card_io, o_card_io_oe, o_irq, line;
   int err_count = 0;
   int samples_checked = 0;
   int cycles = 0;
   logic [7:0] cms [5] = '{8'h01, 8'h09, 8'h05, 8'h0D, 8'h09};
   logic [7:0] mds [5] = '{8'h00, 8'h40, 8'h80, 8'hC0, 8'h20};
   logic [7:0] exps [5] = '{8'hC5, 8'hA3, 8'h3A, 8'h5C, 8'h8A};
   always #2.5 i_sys_clk = ~i_sys_clk;
   scf_smartcard_format_transmit_end_flag #(.ETU(ETU)) DUT (
      .i_sys_clk(i_sys_clk),
      .i_rst_n(i_rst_n),
      .i_addr(i_addr),
      .i_wdata(i_wdata),
      .i_wr(i_wr),
      .i_rd(i_rd),
      .o_rdata(o_rdata),
      .i_card_io(line),
      .o_card_io(o_card_io),
      .o_card_io_oe(o_card_io_oe),
      .i_rx_valid(i_rx_valid),
      .i_rx_raw(i_rx_raw),
      .o_irq(o_irq)
   );
   scf_card_model #(.ETU(ETU)) u_card (
      .i_clk(i_sys_clk),
      .i_rst_n(i_rst_n),
      .i_io(o_card_io),
      .i_oe(o_card_io_oe),
      .i_err_req(err_req),
      .o_line(line),
      .o_byte(rx_byte)
   );
   task automatic results;
      $display("mismatches %0d, checks %0d", err_count, samples_checked);
      if (err_count == 0 && samples_checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : results
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      i_addr <= a;
      i_wdata <= v;
      i_wr <= 1'b1;
      @(posedge i_sys_clk);
      i_wr <= 1'b0;
      @(posedge i_sys_clk);
   endtask : wr
   task automatic rd(input logic [3:0] a);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_sys_clk);
      i_rd <= 1'b0;
      #1 d = o_rdata;
      @(posedge i_sys_clk);
   endtask : rd
   // card mode, mode and data, then start by clearing the empty flag
   task automatic send(input logic [7:0] cm, input logic [7:0] md, input logic [7:0] v);
      int n;
      wr(ADDR_CARD_MODE, cm);
      wr(ADDR_MODE, md);
      wr(ADDR_CONTROL, 8'h20);
      wr(ADDR_TX_DATA, v);
      rd(ADDR_STATUS);
      wr(ADDR_STATUS, 8'h00);
      for (n = 0; n < 20 && !o_card_io_oe; n++) @(posedge i_sys_clk);
      for (n = 0; n < 100 && o_card_io_oe; n++) @(posedge i_sys_clk);
      repeat (3 * ETU) @(posedge i_sys_clk);
   endtask : send
   always @(posedge i_sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         err_count++;
         results();
      end
   end
   initial begin
      repeat (3) @(posedge i_sys_clk);
      i_rst_n <= 1'b1;
      rd(ADDR_CARD_MODE);
      check(d, 8'hF2);
      rd(ADDR_STATUS);
      check(d, 8'h84);
      rd(4'hF);
      check(d, 8'h00);
      wr(ADDR_CARD_MODE, 8'hFF);
      rd(ADDR_CARD_MODE);
      check(d, 8'hFF);
      wr(ADDR_IRQ_MASK, 8'h01);
      for (int i = 0; i < 5; i++) begin
         send(cms[i], mds[i], 8'hC5);
         rd(ADDR_STATUS);
         check(d, 8'h84);
         check(rx_byte & (i == 4 ? 8'hFE : 8'hFF), exps[i]);
         rd(ADDR_IRQ_STAT);
         check(d, 8'h01);
         wr(ADDR_IRQ_STAT, 8'hFF);
      end
      err_req <= 1'b1;
      wr(ADDR_IRQ_MASK, 8'h02);
      send(8'h01, 8'h00, 8'h3C);
      rd(ADDR_STATUS);
      check(d, 8'h94);
      check({7'h00, o_irq}, 8'h01);
      wr(ADDR_IRQ_MASK, 8'h00);
      check({7'h00, o_irq}, 8'h00);
      wr(ADDR_STATUS, 8'h80);
      wr(ADDR_IRQ_STAT, 8'hFF);
      err_req <= 1'b0;
      rd(ADDR_STATUS);
      check(d, 8'h84);
      wr(ADDR_STATUS, 8'h00);
      rd(ADDR_STATUS);
      check(d & 8'h04, 8'h00);
      wr(ADDR_CONTROL, 8'h00);
      rd(ADDR_STATUS);
      check(d, 8'h84);
      repeat (60) @(posedge i_sys_clk);
      wr(ADDR_CARD_MODE, 8'h0D);
      i_rx_raw <= 8'h3B;
      i_rx_valid <= 1'b1;
      @(posedge i_sys_clk);
      i_rx_valid <= 1'b0;
      rd(ADDR_RX_DATA);
      check(d, 8'h23);
      results();
   end
endmodule : scf_smartcard_format_transmit_end_flag_bench
